// ---- verilog/gpio_port.v ----
// Notes on behaviour
// (RULE1) eight drive modes per pin
// (RULE2) analog mode disables input and output
// (RULE3) five ports, up to eight pins, 36 total
// (RULE4) reset leaves every pin fully disabled
// (RULE5) output data register, readable pin state
// (RULE6) per-pin interrupt, one request per port
// (RULE7) separate input and output buffer enables
// (RULE8) per-pin CMOS or LVTTL threshold bit
// (RULE9) per-pin slew rate selection bit
// (RULE10) per-pin selector: data or peripheral signal
// (RULE11) pin level synchronised two stages first
`include "gpio_regs.vh"

module gpio_port
(
    input  wire         pclk,
    input  wire         presetn,
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [11:0]  paddr,
    input  wire [31:0]  pwdata,
    output reg  [31:0]  prdata,
    output wire         pready,
    output reg          pslverr,
    input  wire [35:0]  pin_in,
    output wire [35:0]  pin_out,
    output wire [35:0]  pin_oe,
    output wire [35:0]  pin_pu_en,
    output wire [35:0]  pin_pd_en,
    output wire [35:0]  pin_ie,
    output wire [35:0]  pin_lvttl,
    output wire [35:0]  pin_slow,
    output wire [35:0]  pin_analog,
    input  wire [107:0] periph_out,
    output wire [35:0]  periph_in,
    output wire [4:0]   irq
);
    // register state, one slice per port laid side by side: eight bits, 24 for mode, 16 for select
    reg  [39:0]  out_q;
    reg  [119:0] mode_q;
    reg  [39:0]  ien_q;
    reg  [39:0]  oen_q;
    reg  [39:0]  thr_q;
    reg  [39:0]  slew_q;
    reg  [79:0]  sel_q;
    reg  [39:0]  stat_q;
    reg  [39:0]  mask_q;
    reg  [39:0]  state_q;

    wire [35:0]  sync_lvl;
    wire [35:0]  ie_w;
    wire [39:0]  lvl_d;
    wire [39:0]  evt;
    wire [2:0]   a_port;
    wire [5:0]   a_off;
    wire         a_ok;
    wire         wr;
    wire [2:0]   rp;
    reg  [31:0]  rd_d;
    reg          err_d;

    // true when offset belongs to the register map
    function known_off;
        input [5:0] off;
        begin
            case (off)
                `OFF_OUT_DATA, `OFF_PIN_STATE, `OFF_DRIVE_MODE,
                `OFF_BUF_EN, `OFF_PAD_CFG, `OFF_PIN_SEL,
                `OFF_INT_STAT, `OFF_INT_MASK: known_off = 1'b1;
                default:                      known_off = 1'b0;
            endcase
        end
    endfunction

    // write strobe for one port and one offset
    function hit;
        input         w;
        input [2:0]   port;
        input integer want;
        input [5:0]   off;
        input [5:0]   tgt;
        begin
            // the loop index arrives whole; only its low bits name a port
            hit = w & (port == want[2:0]) & (off == tgt);
        end
    endfunction

    // one port's byte out of a 40-bit bank; a missing port gives zero
    function [7:0] byte_of;
        input [39:0] bank;
        input [2:0]  port;
        begin
            case (port)
                3'h0:    byte_of = bank[7:0];
                3'h1:    byte_of = bank[15:8];
                3'h2:    byte_of = bank[23:16];
                3'h3:    byte_of = bank[31:24];
                3'h4:    byte_of = bank[39:32];
                default: byte_of = 8'h00;
            endcase
        end
    endfunction

    // one port's mode word; a fixed case avoids a variable multiply
    function [23:0] mode_of;
        input [119:0] bank;
        input [2:0]   port;
        begin
            case (port)
                3'h0:    mode_of = bank[23:0];
                3'h1:    mode_of = bank[47:24];
                3'h2:    mode_of = bank[71:48];
                3'h3:    mode_of = bank[95:72];
                3'h4:    mode_of = bank[119:96];
                default: mode_of = 24'h00_0000;
            endcase
        end
    endfunction

    // one port's selector word, two bits per pin
    function [15:0] sel_of;
        input [79:0] bank;
        input [2:0]  port;
        begin
            case (port)
                3'h0:    sel_of = bank[15:0];
                3'h1:    sel_of = bank[31:16];
                3'h2:    sel_of = bank[47:32];
                3'h3:    sel_of = bank[63:48];
                3'h4:    sel_of = bank[79:64];
                default: sel_of = 16'h0000;
            endcase
        end
    endfunction

    // address decode; upper address bits must be zero
    assign a_port = paddr[8:6];
    assign a_off  = paddr[5:0];
    assign a_ok   = (paddr[11:9] == 3'h0) && (a_port < 3'h5) // RULE3
                    && known_off(a_off);
    assign rp     = a_ok ? a_port : 3'h0;

    // zero wait states; the read word is prepared in the setup cycle
    assign pready = 1'b1;
    assign wr     = psel & penable & pwrite & a_ok;

    // pins reach the system clock through two flops
    pin_sync u_sync
    (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in (pin_in),
        .sync_out (sync_lvl)                                      // RULE11
    );

    // disabled inputs read as zero, so they cannot raise events
    assign lvl_d = {4'h0, sync_lvl & ie_w};                       // RULE11
    // any change of an enabled pin is an event; turning the input
    // buffer on or off can itself show as one edge
    assign evt   = (lvl_d ^ state_q) & `PIN_MASK;                 // RULE6

    // pin state register samples the synchronised level
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= 40'h00_0000_0000;
        else
            state_q <= lvl_d;                                     // RULE5
    end

    // per-port register banks
    genvar p;
    generate
        for (p = 0; p < `PORT_COUNT; p = p + 1)
        begin : g_port
            // reset leaves mode analog and both buffers off
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    out_q[p*8 +: 8]   <= `RST_BYTE;               // RULE4
                    mode_q[p*24 +: 24] <= `RST_MODE;              // RULE4
                    ien_q[p*8 +: 8]   <= `RST_BYTE;               // RULE4
                    oen_q[p*8 +: 8]   <= `RST_BYTE;               // RULE4
                    thr_q[p*8 +: 8]   <= `RST_BYTE;
                    slew_q[p*8 +: 8]  <= `RST_BYTE;
                    sel_q[p*16 +: 16] <= `RST_SEL;
                    mask_q[p*8 +: 8]  <= `RST_BYTE;
                end
                else
                begin
                    if (hit(wr, a_port, p, a_off, `OFF_OUT_DATA))
                        out_q[p*8 +: 8] <= pwdata[7:0];           // RULE5
                    if (hit(wr, a_port, p, a_off, `OFF_DRIVE_MODE))
                        mode_q[p*24 +: 24] <= pwdata[23:0];       // RULE1
                    if (hit(wr, a_port, p, a_off, `OFF_BUF_EN))
                    begin
                        ien_q[p*8 +: 8] <= pwdata[`BUF_IN_LSB +: 8];
                        oen_q[p*8 +: 8] <= pwdata[`BUF_OUT_LSB +: 8];
                    end
                    if (hit(wr, a_port, p, a_off, `OFF_PAD_CFG))
                    begin
                        thr_q[p*8 +: 8]  <= pwdata[`CFG_THR_LSB +: 8];
                        slew_q[p*8 +: 8] <= pwdata[`CFG_SLEW_LSB +: 8];
                    end
                    if (hit(wr, a_port, p, a_off, `OFF_PIN_SEL))
                        sel_q[p*16 +: 16] <= pwdata[15:0];        // RULE10
                    if (hit(wr, a_port, p, a_off, `OFF_INT_MASK))
                        mask_q[p*8 +: 8] <= pwdata[7:0];
                end
            end

            // sticky status: write one clears, a new event wins
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    stat_q[p*8 +: 8] <= `RST_BYTE;
                else if (hit(wr, a_port, p, a_off, `OFF_INT_STAT))
                    stat_q[p*8 +: 8] <= (stat_q[p*8 +: 8]
                                         & ~pwdata[7:0])
                                        | evt[p*8 +: 8];          // RULE6
                else
                    stat_q[p*8 +: 8] <= stat_q[p*8 +: 8]
                                        | evt[p*8 +: 8];          // RULE6
            end

            // one level request per port from unmasked status
            assign irq[p] = |(stat_q[p*8 +: 8] & mask_q[p*8 +: 8]); // RULE6
        end
    endgenerate

    // per-pin pad logic, 36 pins on the flat pin buses
    genvar n;
    generate
        for (n = 0; n < 36; n = n + 1)
        begin : g_pin
            pin_drive u_drv
            (
                .mode       (mode_q[n*3 +: 3]),                   // RULE1
                .out_buf_en (oen_q[n]),                           // RULE7
                .in_buf_en  (ien_q[n]),                           // RULE7
                .sel        (sel_q[n*2 +: 2]),                    // RULE10
                .data_bit   (out_q[n]),                           // RULE5
                .periph     (periph_out[n*3 +: 3]),
                .drv_val    (pin_out[n]),
                .drv_oe     (pin_oe[n]),
                .pu_en      (pin_pu_en[n]),
                .pd_en      (pin_pd_en[n]),
                .ie         (ie_w[n]),
                .analog     (pin_analog[n])                       // RULE2
            );
        end
    endgenerate

    assign pin_ie    = ie_w;
    assign pin_lvttl = thr_q[35:0];                               // RULE8
    assign pin_slow  = slew_q[35:0];                              // RULE9
    assign periph_in = state_q[35:0];

    // read word selection; addresses beyond the last port read as zero
    always @*
    begin
        rd_d  = 32'h0000_0000;
        err_d = ~a_ok;
        case (a_off)
            `OFF_OUT_DATA:   rd_d[7:0]  = byte_of(out_q, rp);
            `OFF_PIN_STATE:  rd_d[7:0]  = byte_of(state_q, rp);   // RULE5
            `OFF_DRIVE_MODE: rd_d[23:0] = mode_of(mode_q, rp);
            `OFF_BUF_EN:
            begin
                rd_d[`BUF_IN_LSB +: 8]  = byte_of(ien_q, rp);
                rd_d[`BUF_OUT_LSB +: 8] = byte_of(oen_q, rp);
            end
            `OFF_PAD_CFG:
            begin
                rd_d[`CFG_THR_LSB +: 8]  = byte_of(thr_q, rp);
                rd_d[`CFG_SLEW_LSB +: 8] = byte_of(slew_q, rp);
            end
            `OFF_PIN_SEL:    rd_d[15:0] = sel_of(sel_q, rp);
            `OFF_INT_STAT:   rd_d[7:0]  = byte_of(stat_q, rp);
            `OFF_INT_MASK:   rd_d[7:0]  = byte_of(mask_q, rp);
            default:         rd_d = 32'h0000_0000;
        endcase
        if (!a_ok)
            rd_d = 32'h0000_0000;
    end

    // latch read data and error during setup so the access has them
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_d;
            pslverr <= err_d;
        end
        else if (!psel)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end
endmodule

// ---- verilog/gpio_regs.vh ----
`ifndef GPIO_REGS_VH
`define GPIO_REGS_VH

// port register window: paddr[8:6] picks the port, paddr[5:2] the word
`define PORT_COUNT      5
`define PORT_SEL_LSB    6
`define PORT_STRIDE     12'h0040

// word offsets inside one port window
`define OFF_OUT_DATA    6'h00
`define OFF_PIN_STATE   6'h04
`define OFF_DRIVE_MODE  6'h08
`define OFF_BUF_EN      6'h0C
`define OFF_PAD_CFG     6'h10
`define OFF_PIN_SEL     6'h14
`define OFF_INT_STAT    6'h18
`define OFF_INT_MASK    6'h1C

// field positions
`define BUF_IN_LSB      0
`define BUF_OUT_LSB     8
`define CFG_THR_LSB     0
`define CFG_SLEW_LSB    8

// reset values: every pin starts analog with both buffers off
`define RST_BYTE        8'h00
`define RST_MODE        24'h00_0000
`define RST_SEL         16'h0000

// implemented pins: four full ports and a four-pin last port
`define PIN_MASK        40'h0F_FFFF_FFFF

// drive mode codes
`define DM_ANALOG       3'h0
`define DM_INPUT        3'h1
`define DM_WUP_SDN      3'h2
`define DM_SUP_WDN      3'h3
`define DM_OD_LOW       3'h4
`define DM_OD_HIGH      3'h5
`define DM_STRONG       3'h6
`define DM_WEAK         3'h7

// output source codes
`define SEL_DATA        2'h0

`endif

// ---- verilog/pin_sync.v ----
// two flip-flop synchroniser; only the second stage leaves the module
module pin_sync
(
    input  wire        clk,
    input  wire        rst_n,
    input  wire [35:0] async_in,
    output reg  [35:0] sync_out
);
    reg [35:0] meta_q;

    // first stage feeds the second stage and nothing else
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q   <= 36'h0_0000_0000;
            sync_out <= 36'h0_0000_0000;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ---- verilog/pin_drive.v ----
`include "gpio_regs.vh"

// one pin: output source selection and drive mode decode
module pin_drive
(
    input  wire [2:0] mode,
    input  wire       out_buf_en,
    input  wire       in_buf_en,
    input  wire [1:0] sel,
    input  wire       data_bit,
    input  wire [2:0] periph,
    output reg        drv_val,
    output reg        drv_oe,
    output reg        pu_en,
    output reg        pd_en,
    output wire       ie,
    output wire       analog
);
    reg  v;
    wire ob;

    // analog kills both digital paths whatever the buffer enables say
    assign analog = (mode == `DM_ANALOG);                         // RULE2
    assign ie     = in_buf_en & ~analog;                          // RULE7
    assign ob     = out_buf_en & ~analog & (mode != `DM_INPUT);   // RULE7

    // pick the data register or one of three peripheral signals
    always @*
    begin
        case (sel)                                                // RULE10
            `SEL_DATA: v = data_bit;
            2'h1:      v = periph[0];
            2'h2:      v = periph[1];
            default:   v = periph[2];
        endcase
    end

    // weak levels use the pulls, strong levels use the driver
    always @*
    begin
        drv_val = v;
        drv_oe  = 1'b0;
        pu_en   = 1'b0;
        pd_en   = 1'b0;
        case (mode)                                               // RULE1
            `DM_WUP_SDN:
            begin
                drv_oe = ob & ~v;
                pu_en  = ob & v;
            end
            `DM_SUP_WDN:
            begin
                drv_oe = ob & v;
                pd_en  = ob & ~v;
            end
            `DM_OD_LOW:  drv_oe = ob & ~v;
            `DM_OD_HIGH: drv_oe = ob & v;
            `DM_STRONG:  drv_oe = ob;
            `DM_WEAK:
            begin
                pu_en = ob & v;
                pd_en = ob & ~v;
            end
            default:     drv_oe = 1'b0;
        endcase
    end
endmodule

// ---- bench/gpio_port_asserts.sv ----
module gpio_port_asserts
(
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [35:0] pin_in,
    input wire [35:0] pin_oe,
    input wire [35:0] pin_pu_en,
    input wire [35:0] pin_pd_en,
    input wire [35:0] pin_ie,
    input wire [35:0] pin_lvttl,
    input wire [35:0] pin_slow,
    input wire [35:0] pin_analog,
    input wire [35:0] periph_in,
    input wire [4:0]  irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a completed write is the only legal cause of a config change
    wire wr = psel && penable && pwrite;
    wire [35:0] act = pin_oe | pin_ie | pin_pu_en | pin_pd_en;
    // pin 0 held still with its input open long enough to pass both stages
    sequence s_held;
        (pin_ie[0] && $stable(pin_in[0])) [*4];
    endsequence
    sequence s_rise;
        pin_ie[0] && $rose(pin_in[0]) && !periph_in[0];
    endsequence
    a_reset_off: assert property (
        $rose(presetn) |-> act == 36'h0_0000_0000 && irq == 5'h00)
        else $error("pin active right after reset");
    a_analog_off: assert property (
        (pin_analog & act) == 36'h0_0000_0000)
        else $error("analog pin has a live buffer");
    a_zero_wait: assert property (
        psel && penable |-> pready) else $error("access phase stalled");
    // the bus outputs are cleared at the first idle edge, so look one later
    a_idle_quiet: assert property (
        !psel [*2] |-> !pslverr && prdata == 32'h0000_0000)
        else $error("bus outputs not quiet when idle");
    a_sync_pass: assert property (
        s_held |-> periph_in[0] == pin_in[0])
        else $error("settled pin level not seen");
    a_sync_delay: assert property (
        s_rise and $past(pin_in[0], 2) == 1'b0 |=> !periph_in[0] [*2])
        else $error("pin level bypassed a stage");
    a_irq_cause: assert property (
        $rose(irq[4]) |-> $changed(periph_in[35:32]) || $past(wr))
        else $error("port request rose without an event");
    a_irq_clear: assert property (
        $fell(irq[4]) |-> $past(wr)) else $error("port request dropped alone");
    a_buf_by_write: assert property (
        $changed(pin_ie) || $changed(pin_analog) |-> $past(wr))
        else $error("input buffer changed without a write");
    a_thr_by_write: assert property (
        $changed(pin_lvttl) |-> $past(wr)) else $error("threshold moved alone");
    a_slew_by_write: assert property (
        $changed(pin_slow) |-> $past(wr)) else $error("slew moved alone");
endmodule

bind gpio_port gpio_port_asserts u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .prdata, .pready, .pslverr, .pin_in, .pin_oe, .pin_pu_en,
    .pin_pd_en, .pin_ie, .pin_lvttl, .pin_slow, .pin_analog, .periph_in,
    .irq);

// ---- bench/pin_world.sv ----
// the board around the pads: external drivers, pulls and floating lines
module pin_world
(
    input  wire        pclk,
    input  wire [35:0] pin_out,
    input  wire [35:0] pin_oe,
    input  wire [35:0] pin_pu_en,
    input  wire [35:0] pin_pd_en,
    input  wire [35:0] ext_val,
    input  wire [35:0] ext_en,
    output wire [35:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] flt_q = 36'h0_0000_0000;
    // an undriven pad wanders so a stale value never reads as valid
    always @(posedge pclk)
        flt_q <= ~flt_q;
    // strong driver wins, then the board, then a pull, else floating
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_pu_en | (~pin_pd_en & flt_q)));
endmodule

// ---- bench/testbench.sv ----
`include "gpio_regs.vh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, q;
    logic [35:0]  pin_in, pin_out, pin_oe, pin_pu_en, pin_pd_en, pin_ie;
    logic [35:0]  pin_lvttl, pin_slow, pin_analog, periph_in, ext_val, ext_en;
    logic [107:0] periph_out;
    logic [4:0]   irq;
    int           fail_count, total_checks, m, s;

    gpio_port u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe,
        .pin_pu_en, .pin_pd_en, .pin_ie, .pin_lvttl, .pin_slow, .pin_analog,
        .periph_out, .periph_in, .irq);
    pin_world u_world (.pclk, .pin_out, .pin_oe, .pin_pu_en, .pin_pd_en,
        .ext_val, .ext_en, .pin_in);

    // 25 MHz bus clock
    initial
    begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end

    task chk(input logic [39:0] seen, input logic [39:0] want);
        total_checks++;
        if (seen !== want)
        begin
            fail_count++;
            $display("FAIL %0t seen %h want %h", $time, seen, want);
        end
    endtask

    // one apb transfer; waits on pready rather than assuming zero wait
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // only the watchdog ends a wait that never gets an answer
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        #1;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1, a, d);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] want);
        xfer(0, a, 32'h0000_0000);
        chk(q, want);
    endtask

    function logic [11:0] ad(input int p, input logic [5:0] o);
        ad = {3'b000, p[2:0], o};
    endfunction

    task note(input string t);
        $display("test %s done", t);
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // the whole run is about 150 cycles; this cuts a hang short
    initial
    begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        $display("FAIL %0t watchdog expired", $time);
        complete_run;
    end

    // main sequence
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, periph_out} = 0;
        ext_val = 0;
        ext_en = 36'hF_FFFF_FFFF;
        presetn = 0;
        repeat (10) @(posedge pclk);
        chk(pin_oe | pin_ie | pin_pu_en | pin_pd_en, 0);
        chk(pin_analog, 36'hF_FFFF_FFFF);
        presetn <= 1;
        rd(ad(0, `OFF_DRIVE_MODE), 0);
        rd(ad(4, `OFF_BUF_EN), 0);
        note("reset");
        wr(ad(0, `OFF_DRIVE_MODE), 32'h00DB_6DB6);
        wr(ad(0, `OFF_BUF_EN), 32'h0000_FF00);
        wr(ad(0, `OFF_OUT_DATA), 32'h0000_00A5);
        chk(pin_out[7:0], 8'hA5);
        chk(pin_oe[7:0], 8'hFF);
        chk(pin_ie[7:0], 8'h00);
        rd(ad(0, `OFF_PIN_STATE), 0);
        wr(ad(0, `OFF_BUF_EN), 32'h0000_FFFF);
        wr(ad(0, `OFF_PIN_STATE), 32'h0000_005A);
        rd(ad(0, `OFF_PIN_STATE), 32'h0000_00A5);
        note("output");
        // every drive mode on port 1, both buffers asked for
        wr(ad(1, `OFF_BUF_EN), 32'h0000_FFFF);
        for (m = 0; m < 8; m++)
        begin
            wr(ad(1, `OFF_DRIVE_MODE), {8'h00, {8{m[2:0]}}});
            rd(ad(1, `OFF_DRIVE_MODE), {8'h00, {8{m[2:0]}}});
            chk(pin_analog[15:8], (m == 0) ? 8'hFF : 8'h00);
            chk(pin_ie[15:8], (m == 0) ? 8'h00 : 8'hFF);
            if (m < 2)
                chk(pin_oe[15:8], 8'h00);
            // oe, pu, pd of pin 8 with its data low, three bits per mode
            s = (24'h30_4300 >> (m * 3)) & 24'h00_0007;
            chk({pin_oe[8], pin_pu_en[8], pin_pd_en[8]}, s);
        end
        note("modes");
        wr(ad(2, `OFF_PAD_CFG), 32'h0000_5A3C);
        rd(ad(2, `OFF_PAD_CFG), 32'h0000_5A3C);
        chk(pin_lvttl, 36'h0_003C_0000);
        chk(pin_slow, 36'h0_005A_0000);
        note("pad");
        // pin 0 carries data bit 0, a one, then each peripheral line in turn
        periph_out <= 108'h2;
        for (s = 0; s < 4; s++)
        begin
            wr(ad(0, `OFF_PIN_SEL), s);
            chk(pin_out[0], (s == 0) ? 1'b1 : periph_out[s - 1]);
        end
        note("select");
        wr(ad(4, `OFF_DRIVE_MODE), 32'h0000_0008);
        wr(ad(4, `OFF_BUF_EN), 32'h0000_0002);
        wr(ad(4, `OFF_INT_STAT), 32'h0000_00FF);
        wr(ad(4, `OFF_INT_MASK), 32'h0000_0002);
        ext_val[33] <= 1;
        // two stages plus the state register: not visible after two edges
        repeat (2) @(posedge pclk);
        #1;
        chk(periph_in[35:32], 4'h0);
        repeat (2) @(posedge pclk);
        #1;
        chk(periph_in[35:32], 4'h2);
        chk(irq, 5'h10);
        rd(ad(4, `OFF_INT_STAT), 32'h0000_0002);
        rd(ad(4, `OFF_PIN_STATE), 32'h0000_0002);
        wr(ad(4, `OFF_INT_STAT), 32'h0000_0002);
        chk(irq, 5'h00);
        wr(ad(4, `OFF_INT_MASK), 0);
        ext_val[33] <= 0;
        repeat (4) @(posedge pclk);
        #1;
        chk(irq, 5'h00);
        rd(ad(4, `OFF_INT_STAT), 32'h0000_0002);
        note("interrupt");
        xfer(0, 12'h140, 0);
        chk({e, q}, 33'h1_0000_0000);
        xfer(1, ad(0, 6'h20), 32'h0000_00FF);
        chk(e, 1);
        note("unmapped");
        complete_run;
    end
endmodule
